// ===== hsec_host.sv
// host controller that drives the transceiver security engine registers
`timescale 1ns/1ps
module hsec_host (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// user command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire hsec_pkg::hsec_cmd_t cmd,
	output logic busy,
	output logic done,
	output hsec_pkg::hsec_res_t res,
	// device register port
	output logic dev_req,
	output logic dev_we,
	output logic [9:0] dev_addr,
	output logic [7:0] dev_wdata,
	input wire logic dev_ack,
	input wire logic [7:0] dev_rdata
);

	hsec_pkg::hsec_st_t q;
	hsec_pkg::hsec_st_t d;
	hsec_pkg::hsec_uop_t u;
	logic [3:0] last_idx;

	function automatic hsec_pkg::hsec_uop_t mk(
		input hsec_pkg::hsec_kind_t k, input logic [9:0] a,
		input logic [7:0] m, input logic [7:0] v);
		hsec_pkg::hsec_uop_t r;
		r.kind = k;
		r.addr = a;
		r.mask = m;
		r.val = v;
		return r;
	endfunction

	// micro-op table: one register access step of each command
	function automatic hsec_pkg::hsec_uop_t hsec_uop(
		input hsec_pkg::hsec_cmd_t c, input logic [3:0] s);
		hsec_pkg::hsec_uop_t r;
		logic [9:0] ka;
		logic [9:0] ca;
		logic [9:0] sa;
		logic [7:0] sm;
		logic [7:0] sv;
		logic [7:0] fl;
		logic [7:0] sw;
		logic [7:0] upv;
		r = mk(hsec_pkg::U_END, 10'h000, 8'h00, 8'h00);
		sw = {5'h00, c.suite}; // suite none passes through
		// per-fifo key slot, suite field, control reg and done flag
		case (c.fifo)
			hsec_pkg::FIFO_SLOT1: begin
				ka = hsec_pkg::ADDR_KEY_SLOT1;
				sa = hsec_pkg::ADDR_SEC_CTRL_C;
				sm = hsec_pkg::M_SLOT1_SUITE;
				sv = sw;
				ca = hsec_pkg::ADDR_SLOT1_CTRL;
				fl = hsec_pkg::F_SLOT1_DONE;
			end
			hsec_pkg::FIFO_SLOT2: begin
				ka = hsec_pkg::ADDR_KEY_SHARED;
				sa = hsec_pkg::ADDR_SEC_CTRL_C;
				sm = hsec_pkg::M_SLOT2_SUITE;
				sv = 8'(sw << hsec_pkg::SH_SLOT2_SUITE);
				ca = hsec_pkg::ADDR_SLOT2_CTRL;
				fl = hsec_pkg::F_SLOT2_DONE;
			end
			hsec_pkg::FIFO_BEACON: begin
				ka = hsec_pkg::ADDR_KEY_SHARED;
				sa = hsec_pkg::ADDR_SEC_CTRL_B;
				sm = hsec_pkg::M_BEACON_SUITE;
				sv = 8'(sw << hsec_pkg::SH_BEACON_SUITE);
				ca = hsec_pkg::ADDR_BEACON_CTRL;
				fl = 8'h00; // beacon has no done flag
			end
			default: begin
				ka = hsec_pkg::ADDR_KEY_NORMAL;
				sa = hsec_pkg::ADDR_SEC_CTRL_A;
				sm = hsec_pkg::M_NORMAL_SUITE;
				sv = sw;
				ca = hsec_pkg::ADDR_NORMAL_CTRL;
				fl = hsec_pkg::F_NORMAL_DONE;
			end
		endcase
		upv = (c.op == hsec_pkg::OP_UP_ENC) ? hsec_pkg::V_UP_ENC :
			hsec_pkg::V_UP_DEC;
		case (c.op)
			hsec_pkg::OP_MAC_TX: begin
				case (s)
					4'h0: r = mk(hsec_pkg::U_KEY, ka, 8'h00, 8'h00);
					4'h1: r = mk(hsec_pkg::U_RMW, sa, sm, sv);
					4'h2: r = mk(hsec_pkg::U_RMW, ca, hsec_pkg::M_TRIG_SEC,
						hsec_pkg::V_TRIG_SEC);
					4'h3: if (fl != 8'h00) begin
						r = mk(hsec_pkg::U_POLL, hsec_pkg::ADDR_INT_FLAG, fl,
							8'h00);
					end
					4'h4: r = mk(hsec_pkg::U_RD, hsec_pkg::ADDR_TX_RESULT,
						8'h00, hsec_pkg::DST_TX);
					4'h5: r = mk(hsec_pkg::U_RD, ca, 8'h00,
						hsec_pkg::DST_CTRL);
					default: r = mk(hsec_pkg::U_END, 10'h000, 8'h00, 8'h00);
				endcase
			end
			hsec_pkg::OP_RX_DECRYPT: begin
				case (s)
					4'h0: r = mk(hsec_pkg::U_KEY, hsec_pkg::ADDR_KEY_RX,
						8'h00, 8'h00);
					4'h1: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_SEC_CTRL_A,
						hsec_pkg::M_RX_SUITE,
						8'(sw << hsec_pkg::SH_RX_SUITE));
					4'h2: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_SEC_CTRL_A,
						hsec_pkg::M_RX_START, hsec_pkg::M_RX_START);
					4'h3: r = mk(hsec_pkg::U_POLL, hsec_pkg::ADDR_INT_FLAG,
						hsec_pkg::F_RX_DONE, 8'h00);
					4'h4: r = mk(hsec_pkg::U_RD, hsec_pkg::ADDR_RX_SEC_RESULT,
						8'h00, hsec_pkg::DST_RX);
					4'h5: if (c.flush_on_err) begin
						r = mk(hsec_pkg::U_SKIPZ, 10'h000, hsec_pkg::M_DEC_ERR,
							8'h00);
					end
					4'h6: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_RX_DISCARD,
						hsec_pkg::M_DISCARD, hsec_pkg::M_DISCARD);
					default: r = mk(hsec_pkg::U_END, 10'h000, 8'h00, 8'h00);
				endcase
			end
			hsec_pkg::OP_RX_SKIP: if (s == 4'h0) begin
				r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_SEC_CTRL_A,
					hsec_pkg::M_SKIP_DEC, hsec_pkg::M_SKIP_DEC);
			end
			hsec_pkg::OP_RX_DISCARD: if (s == 4'h0) begin
				r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_RX_DISCARD,
					hsec_pkg::M_DISCARD, hsec_pkg::M_DISCARD);
			end
			hsec_pkg::OP_WAIT_SECURED: if (s == 4'h0) begin
				r = mk(hsec_pkg::U_POLL, hsec_pkg::ADDR_INT_FLAG,
					hsec_pkg::F_SECURED, 8'h00);
			end
			// header length sits in the frame, so the caller must keep
			// it at 31 octets or less; nothing here can enforce it
			hsec_pkg::OP_UP_ENC, hsec_pkg::OP_UP_DEC: begin
				case (s)
					4'h0: r = mk(hsec_pkg::U_KEY, hsec_pkg::ADDR_KEY_NORMAL,
						8'h00, 8'h00);
					4'h1: r = mk(hsec_pkg::U_NONCE, hsec_pkg::ADDR_NONCE,
						8'h00, 8'h00);
					4'h2: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_SEC_CTRL_A,
						hsec_pkg::M_NORMAL_SUITE, sw);
					4'h3: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_SEC_CTRL_C,
						hsec_pkg::M_UP_MODE, upv);
					4'h4: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_NORMAL_CTRL,
						hsec_pkg::M_TRIG_SEC,
						(c.op == hsec_pkg::OP_UP_ENC) ? hsec_pkg::V_TRIG_SEC :
						hsec_pkg::V_TRIG_ONLY);
					4'h5: r = mk(hsec_pkg::U_POLL, hsec_pkg::ADDR_INT_FLAG,
						hsec_pkg::F_NORMAL_DONE, 8'h00);
					4'h6: r = mk(hsec_pkg::U_RD, hsec_pkg::ADDR_TX_RESULT,
						8'h00, hsec_pkg::DST_TX);
					4'h7: r = mk(hsec_pkg::U_RD, hsec_pkg::ADDR_RX_SEC_RESULT,
						8'h00, hsec_pkg::DST_RX);
					// leaving the mode bits set would turn later sends
					// into in-place operations
					4'h8: r = mk(hsec_pkg::U_RMW, hsec_pkg::ADDR_SEC_CTRL_C,
						hsec_pkg::M_UP_MODE, hsec_pkg::V_UP_OFF);
					4'h9: r = mk(hsec_pkg::U_SKIPZ, 10'h000,
						hsec_pkg::M_INTEG_ERR, 8'h00);
					4'ha: r = mk(hsec_pkg::U_WR, hsec_pkg::ADDR_RX_SEC_RESULT,
						8'h00, hsec_pkg::M_INTEG_ERR);
					default: r = mk(hsec_pkg::U_END, 10'h000, 8'h00, 8'h00);
				endcase
			end
			default: r = mk(hsec_pkg::U_END, 10'h000, 8'h00, 8'h00);
		endcase
		return r;
	endfunction

	// next-state logic; every device access waits for its ack
	always_comb begin
		u = hsec_uop(q.cmd, q.step);
		last_idx = (u.kind == hsec_pkg::U_KEY) ? hsec_pkg::KEY_LAST :
			hsec_pkg::NONCE_LAST;
		d = q;
		if (ce) begin
			d.done = 1'b0;
			case (q.state)
				hsec_pkg::ST_IDLE: if (cmd_valid) begin
					d.cmd = cmd;
					d.step = 4'h0;
					d.stat = 8'h00;
					d.rx_security_result_reg = 8'h00;
					d.ctrl = 8'h00;
					d.state = hsec_pkg::ST_FETCH;
				end
				hsec_pkg::ST_FETCH: begin
					d.idx = 4'h0;
					case (u.kind)
						hsec_pkg::U_KEY, hsec_pkg::U_NONCE:
							d.state = hsec_pkg::ST_BURST;
						hsec_pkg::U_RMW: d.state = hsec_pkg::ST_RMW_RD;
						hsec_pkg::U_POLL: d.state = hsec_pkg::ST_POLL;
						hsec_pkg::U_RD: d.state = hsec_pkg::ST_READ;
						hsec_pkg::U_WR: d.state = hsec_pkg::ST_WRITE;
						// conditional step: skip the next one when clear
						hsec_pkg::U_SKIPZ: d.step = q.step +
							(((q.rx_security_result_reg & u.mask) == 8'h00) ? 4'h2 : 4'h1);
						default: d.state = hsec_pkg::ST_DONE;
					endcase
				end
				hsec_pkg::ST_BURST: if (!q.req) begin
					d.req = 1'b1;
					d.we = 1'b1;
					d.addr = u.addr + {6'h00, q.idx};
					d.wdata = (u.kind == hsec_pkg::U_KEY) ?
						q.cmd.key[{q.idx, 3'h0} +: 8] :
						q.cmd.nonce[{q.idx, 3'h0} +: 8];
				end else if (dev_ack) begin
					d.req = 1'b0;
					if (q.idx == last_idx) begin
						d.step = q.step + 4'h1;
						d.state = hsec_pkg::ST_FETCH;
					end else begin
						d.idx = q.idx + 4'h1;
					end
				end
				hsec_pkg::ST_RMW_RD: if (!q.req) begin
					d.req = 1'b1;
					d.we = 1'b0;
					d.addr = u.addr;
				end else if (dev_ack) begin
					d.req = 1'b0;
					d.merged = (dev_rdata & ~u.mask) | (u.val & u.mask);
					d.state = hsec_pkg::ST_WRITE;
				end
				hsec_pkg::ST_WRITE: if (!q.req) begin
					d.req = 1'b1;
					d.we = 1'b1;
					d.addr = u.addr;
					d.wdata = (u.kind == hsec_pkg::U_RMW) ? q.merged : u.val;
				end else if (dev_ack) begin
					d.req = 1'b0;
					d.step = q.step + 4'h1;
					d.state = hsec_pkg::ST_FETCH;
				end
				// polling repeats the read until the flag shows
				hsec_pkg::ST_POLL, hsec_pkg::ST_READ: if (!q.req) begin
					d.req = 1'b1;
					d.we = 1'b0;
					d.addr = u.addr;
				end else if (dev_ack) begin
					d.req = 1'b0;
					if (q.state == hsec_pkg::ST_READ) begin
						if (u.val == hsec_pkg::DST_TX) d.stat = dev_rdata;
						else if (u.val == hsec_pkg::DST_RX) d.rx_security_result_reg = dev_rdata;
						else d.ctrl = dev_rdata;
					end
					if (q.state == hsec_pkg::ST_READ ||
						(dev_rdata & u.mask) != 8'h00) begin
						d.step = q.step + 4'h1;
						d.state = hsec_pkg::ST_FETCH;
					end
				end
				hsec_pkg::ST_DONE: begin
					d.done = 1'b1;
					d.state = hsec_pkg::ST_IDLE;
					d.res = '0;
					if (q.cmd.fifo == hsec_pkg::FIFO_SLOT1 &&
						q.cmd.op == hsec_pkg::OP_MAC_TX) begin
						d.res.fail = ~q.stat[hsec_pkg::B_SLOT1_OK];
						d.res.retry = q.ctrl[hsec_pkg::RETRY_LSB +: 2];
						d.res.no_time = q.stat[hsec_pkg::B_SLOT1_NOTIME];
					end else if (q.cmd.fifo == hsec_pkg::FIFO_SLOT2 &&
						q.cmd.op == hsec_pkg::OP_MAC_TX) begin
						d.res.fail = ~q.stat[hsec_pkg::B_SLOT2_OK];
						d.res.retry = q.ctrl[hsec_pkg::RETRY_LSB +: 2];
						d.res.no_time = q.stat[hsec_pkg::B_SLOT2_NOTIME];
					end else begin
						d.res.fail = q.stat[hsec_pkg::B_NORMAL_FAIL];
						d.res.retry = q.stat[hsec_pkg::RETRY_LSB +: 2];
					end
					d.res.chan_busy = q.stat[hsec_pkg::B_CHAN_BUSY];
					d.res.decrypt_err = q.rx_security_result_reg[hsec_pkg::B_DEC_ERR];
					d.res.integrity_err = q.rx_security_result_reg[hsec_pkg::B_INTEG_ERR];
				end
				default: d.state = hsec_pkg::ST_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign cmd_ready = (q.state == hsec_pkg::ST_IDLE);
	assign busy = (q.state != hsec_pkg::ST_IDLE);
	assign done = q.done;
	assign res = q.res;
	assign dev_req = q.req;
	assign dev_we = q.we;
	assign dev_addr = q.addr;
	assign dev_wdata = q.wdata;

	// checks on the register traffic and the command handshake
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic wr;
	assign wr = q.req && q.we && ce;
	sequence s_accept;
		q.req && dev_ack && ce;
	endsequence
	sequence s_cmd_taken;
		cmd_valid && cmd_ready && ce;
	endsequence

	a_req_release: assert property (s_accept |=> !q.req)
		else $error("request not dropped after ack");
	a_cmd_busy: assert property (s_cmd_taken |=> busy ##0 !done)
		else $error("command taken but not busy");
	a_key_range: assert property (
		wr && q.state == hsec_pkg::ST_BURST &&
		u.kind == hsec_pkg::U_KEY |->
		q.addr >= hsec_pkg::ADDR_KEY_NORMAL &&
		q.addr <= hsec_pkg::ADDR_KEY_END)
		else $error("key byte outside key memory");
	a_nonce_range: assert property (
		wr && u.kind == hsec_pkg::U_NONCE |->
		q.addr >= hsec_pkg::ADDR_NONCE &&
		q.addr <= hsec_pkg::ADDR_NONCE_END)
		else $error("nonce byte outside nonce registers");
	a_tx_trigger: assert property (
		wr && q.cmd.op == hsec_pkg::OP_MAC_TX &&
		q.state == hsec_pkg::ST_WRITE && q.step == 4'h2 |->
		(q.wdata & hsec_pkg::M_TRIG_SEC) == hsec_pkg::V_TRIG_SEC)
		else $error("secured send without enable and trigger");
	a_up_trigger: assert property (
		wr && q.addr == hsec_pkg::ADDR_NORMAL_CTRL &&
		q.cmd.op == hsec_pkg::OP_UP_DEC |->
		(q.wdata & hsec_pkg::M_TRIG_SEC) == hsec_pkg::V_TRIG_ONLY)
		else $error("upper decrypt trigger wrong");
	a_up_enc_trigger: assert property (
		wr && q.addr == hsec_pkg::ADDR_NORMAL_CTRL &&
		q.cmd.op == hsec_pkg::OP_UP_ENC |->
		(q.wdata & hsec_pkg::M_TRIG_SEC) == hsec_pkg::V_TRIG_SEC)
		else $error("upper encrypt trigger wrong");
	a_rx_start: assert property (
		wr && q.cmd.op == hsec_pkg::OP_RX_DECRYPT &&
		q.addr == hsec_pkg::ADDR_SEC_CTRL_A &&
		(q.wdata & hsec_pkg::M_RX_START) != 8'h00 |->
		3'(q.wdata >> hsec_pkg::SH_RX_SUITE) == q.cmd.suite)
		else $error("decrypt started with wrong suite");
	a_err_clear: assert property (
		wr && q.addr == hsec_pkg::ADDR_RX_SEC_RESULT |->
		q.wdata == hsec_pkg::M_INTEG_ERR)
		else $error("integrity error clear value wrong");
	a_skip_bit: assert property (
		wr && q.cmd.op == hsec_pkg::OP_RX_SKIP |->
		(q.wdata & hsec_pkg::M_SKIP_DEC) != 8'h00)
		else $error("skip write lacks ignore bit");
	// a command may be taken in the done cycle itself
	a_done_pulse: assert property (done && ce |=> !done ##0
		busy == $past(cmd_valid))
		else $error("done not a single pulse");

endmodule

// ===== hsec_pkg.sv
// shared types and constants for the frame security host controller
package hsec_pkg;

	// device register byte addresses
	localparam logic [9:0] ADDR_RX_DISCARD = 10'h00d;
	localparam logic [9:0] ADDR_BEACON_CTRL = 10'h01a;
	localparam logic [9:0] ADDR_NORMAL_CTRL = 10'h01b;
	localparam logic [9:0] ADDR_SLOT1_CTRL = 10'h01c;
	localparam logic [9:0] ADDR_SLOT2_CTRL = 10'h01d;
	localparam logic [9:0] ADDR_TX_RESULT = 10'h024;
	localparam logic [9:0] ADDR_SEC_CTRL_A = 10'h02c;
	localparam logic [9:0] ADDR_SEC_CTRL_B = 10'h02d;
	localparam logic [9:0] ADDR_RX_SEC_RESULT = 10'h030;
	localparam logic [9:0] ADDR_INT_FLAG = 10'h031;
	localparam logic [9:0] ADDR_SEC_CTRL_C = 10'h037;
	localparam logic [9:0] ADDR_NONCE = 10'h240;
	localparam logic [9:0] ADDR_NONCE_END = 10'h24c;
	localparam logic [9:0] ADDR_KEY_NORMAL = 10'h280;
	localparam logic [9:0] ADDR_KEY_SLOT1 = 10'h290;
	localparam logic [9:0] ADDR_KEY_SHARED = 10'h2a0;
	localparam logic [9:0] ADDR_KEY_RX = 10'h2b0;
	localparam logic [9:0] ADDR_KEY_END = 10'h2bf;

	// last byte index of a key and of a nonce burst
	localparam logic [3:0] KEY_LAST = 4'hf;
	localparam logic [3:0] NONCE_LAST = 4'hc;

	// field masks and values
	localparam logic [7:0] M_TRIG_SEC = 8'h03;
	localparam logic [7:0] V_TRIG_SEC = 8'h03;
	localparam logic [7:0] V_TRIG_ONLY = 8'h01;
	localparam logic [7:0] M_SKIP_DEC = 8'h80;
	localparam logic [7:0] M_RX_START = 8'h40;
	localparam logic [7:0] M_RX_SUITE = 8'h38;
	localparam logic [7:0] M_NORMAL_SUITE = 8'h07;
	localparam logic [7:0] M_SLOT1_SUITE = 8'h07;
	localparam logic [7:0] M_SLOT2_SUITE = 8'h38;
	localparam logic [7:0] M_BEACON_SUITE = 8'h70;
	localparam int SH_RX_SUITE = 3;
	localparam int SH_SLOT2_SUITE = 3;
	localparam int SH_BEACON_SUITE = 4;
	localparam logic [7:0] M_UP_MODE = 8'hc0;
	localparam logic [7:0] V_UP_ENC = 8'h40;
	localparam logic [7:0] V_UP_DEC = 8'h80;
	localparam logic [7:0] V_UP_OFF = 8'h00;
	localparam logic [7:0] F_NORMAL_DONE = 8'h01;
	localparam logic [7:0] F_SLOT1_DONE = 8'h02;
	localparam logic [7:0] F_SLOT2_DONE = 8'h04;
	localparam logic [7:0] F_RX_DONE = 8'h08;
	localparam logic [7:0] F_SECURED = 8'h10;
	localparam logic [7:0] M_DEC_ERR = 8'h04;
	localparam logic [7:0] M_INTEG_ERR = 8'h40;
	localparam logic [7:0] M_DISCARD = 8'h01;
	localparam int B_NORMAL_FAIL = 0;
	localparam int B_SLOT1_OK = 1;
	localparam int B_SLOT2_OK = 2;
	localparam int B_SLOT1_NOTIME = 3;
	localparam int B_SLOT2_NOTIME = 4;
	localparam int B_CHAN_BUSY = 5;
	localparam int B_DEC_ERR = 2;
	localparam int B_INTEG_ERR = 6;
	localparam int RETRY_LSB = 6;

	// security suite codes
	localparam logic [2:0] SUITE_NONE = 3'h0;
	localparam logic [2:0] SUITE_CTR = 3'h1;
	localparam logic [2:0] SUITE_CCM_128 = 3'h2;
	localparam logic [2:0] SUITE_CCM_64 = 3'h3;
	localparam logic [2:0] SUITE_CCM_32 = 3'h4;
	localparam logic [2:0] SUITE_CBC_128 = 3'h5;
	localparam logic [2:0] SUITE_CBC_64 = 3'h6;
	localparam logic [2:0] SUITE_CBC_32 = 3'h7;

	// transmit fifo selection
	localparam logic [1:0] FIFO_NORMAL = 2'h0;
	localparam logic [1:0] FIFO_SLOT1 = 2'h1;
	localparam logic [1:0] FIFO_SLOT2 = 2'h2;
	localparam logic [1:0] FIFO_BEACON = 2'h3;

	// read capture destinations
	localparam logic [7:0] DST_TX = 8'h00;
	localparam logic [7:0] DST_RX = 8'h01;
	localparam logic [7:0] DST_CTRL = 8'h02;

	typedef enum logic [2:0] {
		OP_MAC_TX, OP_RX_DECRYPT, OP_RX_SKIP, OP_UP_ENC,
		OP_UP_DEC, OP_RX_DISCARD, OP_WAIT_SECURED
	} hsec_op_t;

	typedef enum logic [2:0] {
		U_END, U_KEY, U_NONCE, U_RMW, U_POLL, U_RD, U_SKIPZ, U_WR
	} hsec_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_BURST, ST_RMW_RD, ST_WRITE, ST_POLL,
		ST_READ, ST_DONE
	} hsec_state_t;

	typedef struct packed {
		hsec_op_t op;
		logic [1:0] fifo;
		logic [2:0] suite;
		logic flush_on_err;
		logic [127:0] key;
		logic [103:0] nonce;
	} hsec_cmd_t;

	typedef struct packed {
		logic fail;
		logic [1:0] retry;
		logic chan_busy;
		logic no_time;
		logic decrypt_err;
		logic integrity_err;
	} hsec_res_t;

	typedef struct packed {
		hsec_kind_t kind;
		logic [9:0] addr;
		logic [7:0] mask;
		logic [7:0] val;
	} hsec_uop_t;

	typedef struct packed {
		hsec_state_t state;
		logic [3:0] step;
		logic [3:0] idx;
		hsec_cmd_t cmd;
		logic req;
		logic we;
		logic [9:0] addr;
		logic [7:0] wdata;
		logic [7:0] merged;
		logic [7:0] stat;
		logic [7:0] rx_security_result_reg;
		logic [7:0] ctrl;
		logic done;
		hsec_res_t res;
	} hsec_st_t;

endpackage

// ===== hsec_dev_model.sv
// behavioural register model of the transceiver security engine
`timescale 1ns/1ps
module hsec_dev_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic dev_req,
	input wire logic dev_we,
	input wire logic [9:0] dev_addr,
	input wire logic [7:0] dev_wdata,
	output logic dev_ack,
	output logic [7:0] dev_rdata,
	// outcome knobs set by the bench
	input wire logic [3:0] lat,
	input wire logic o_fail,
	input wire logic [1:0] o_retry,
	input wire logic o_busy,
	input wire logic o_notime,
	input wire logic o_decerr,
	input wire logic o_integ,
	input wire logic sec_rx
);
	logic [7:0] mem [0:1023];
	logic [9:0] tx_reg;
	int wait_n, tx_n, rx_n, sends, rx_starts, discards;

	// end of a transmit or an in-place upper operation
	task automatic fin_tx();
		if (tx_reg == 10'h01b && mem[10'h037][7:6] != 2'b00) begin
			mem[10'h031] = mem[10'h031] | 8'h01;
			mem[10'h024][0] = 1'b0;
			if (mem[10'h037][7])
				mem[10'h030][6] = o_integ;
		end else if (tx_reg == 10'h01b) begin
			sends++; // sent as loaded for suite none
			mem[10'h031] = mem[10'h031] | 8'h01;
			mem[10'h024] = {o_retry, o_busy, 4'h0, o_fail};
		end else begin
			sends++;
			mem[tx_reg][7:6] = o_retry;
			if (tx_reg == 10'h01c) begin
				mem[10'h031] = mem[10'h031] | 8'h02;
				mem[10'h024] = {2'b00, o_busy, 1'b0, o_notime, 1'b0,
					~o_fail, 1'b0};
			end else begin
				mem[10'h031] = mem[10'h031] | 8'h04;
				mem[10'h024] = {2'b00, o_busy, o_notime, 1'b0,
					~o_fail, 2'b00};
			end
		end
	endtask

	// register write with the side effects of the control bits
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		if (a == 10'h030)
			mem[a] = mem[a] & ~(d & 8'h40); // writing one clears bit 6 only
		else if (a == 10'h00d && d[0]) begin
			discards++;
			mem[a] = d & 8'hfe;
		end else if (a == 10'h02c && d[6]) begin
			rx_starts++;
			rx_n = 8;
			mem[a] = d & 8'hbf;
		end else begin
			// keys, nonce and suite fields land as written
			mem[a] = d;
			if ((a == 10'h01b || a == 10'h01c || a == 10'h01d) && d[0]) begin
				tx_reg = a;
				tx_n = 10;
			end
		end
	endtask

	// access handshake, flag timing and the receive engine
	always @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 1024; i++)
				mem[i] = 8'h00;
			dev_ack <= 1'b0;
			dev_rdata <= 8'h00;
			wait_n = 0;
			tx_n = 0;
			rx_n = 0;
			sends = 0;
			rx_starts = 0;
			discards = 0;
		end else begin
			dev_ack <= 1'b0;
			dev_rdata <= ~dev_rdata; // idle data toggles so nothing stale looks valid
			if (sec_rx)
				mem[10'h031] = mem[10'h031] | 8'h10;
			if (tx_n != 0) begin
				tx_n--;
				if (tx_n == 0)
					fin_tx();
			end
			if (rx_n != 0) begin
				rx_n--;
				if (rx_n == 0) begin
					mem[10'h031] = mem[10'h031] | 8'h08;
					mem[10'h030][2] = o_decerr;
				end
			end
			if (dev_req && !dev_ack) begin
				if (wait_n == int'(lat)) begin
					wait_n = 0;
					dev_ack <= 1'b1;
					if (dev_we)
						wr(dev_addr, dev_wdata);
					else begin
						dev_rdata <= mem[dev_addr];
						if (dev_addr == 10'h031)
							mem[10'h031] = 8'h00; // flags clear on read
					end
				end else
					wait_n++;
			end
		end
	end
endmodule

// ===== tb_top.sv
// self-checking bench for the security host controller
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic cmd_valid = 1'b0;
	hsec_pkg::hsec_cmd_t cmd = '0;
	logic cmd_ready, busy, done, dev_req, dev_we, dev_ack;
	hsec_pkg::hsec_res_t res;
	logic [9:0] dev_addr;
	logic [7:0] dev_wdata, dev_rdata;
	logic [3:0] lat = 4'h0;
	logic o_fail = 0, o_busy = 0, o_notime = 0, o_decerr = 0;
	logic o_integ = 0, sec_rx = 0;
	logic [1:0] o_retry = 2'h0;
	int mismatches = 0, compares = 0, s, f, sends0;
	time t_done, t_sec;
	logic [9:0] kb [4] = '{10'h280, 10'h290, 10'h2a0, 10'h2a0};
	logic [9:0] sa [4] = '{10'h02c, 10'h037, 10'h037, 10'h02d};
	logic [9:0] cr [4] = '{10'h01b, 10'h01c, 10'h01d, 10'h01a};
	int sh [4] = '{0, 0, 3, 4};

	// 40 MHz clock
	always #12.5 clk = ~clk;

	hsec_host uut (.clk(clk), .reset(reset), .ce(ce),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.busy(busy), .done(done), .res(res), .dev_req(dev_req),
		.dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_ack(dev_ack), .dev_rdata(dev_rdata));

	hsec_dev_model dev (.clk(clk), .reset(reset), .dev_req(dev_req),
		.dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
		.dev_ack(dev_ack), .dev_rdata(dev_rdata), .lat(lat),
		.o_fail(o_fail), .o_retry(o_retry), .o_busy(o_busy),
		.o_notime(o_notime), .o_decerr(o_decerr), .o_integ(o_integ),
		.sec_rx(sec_rx));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one command, key and nonce bytes counting up from seed
	task automatic run(input hsec_pkg::hsec_op_t op, input logic [1:0] fi,
		input logic [2:0] su, input logic fl, input logic [7:0] seed);
		int n;
		@(negedge clk);
		cmd.op = op;
		cmd.fifo = fi;
		cmd.suite = su;
		cmd.flush_on_err = fl;
		for (n = 0; n < 16; n++)
			cmd.key[8*n +: 8] = seed + 8'(n);
		for (n = 0; n < 13; n++)
			cmd.nonce[8*n +: 8] = seed + 8'(n);
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		check({busy, cmd_ready}, 2'b10);
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		check(32'(n < 4000), 32'd1);
		check({busy, cmd_ready}, 2'b01);
	endtask

	// the run must not take longer than this
	initial begin
		#750000;
		mismatches++;
		test_done();
	end

	initial begin
		repeat (2) @(negedge clk);
		reset = 1'b0;
		// every suite code, every fifo, acknowledge latency 0 to 7
		for (s = 0; s < 8; s++) begin
			f = s % 4;
			lat = 4'(s);
			o_fail = s[0];
			o_busy = s[0];
			o_retry = s[2:1];
			o_notime = s[1];
			run(hsec_pkg::OP_MAC_TX, 2'(f), 3'(s), 1'b0, 8'(16 * s));
			check((dev.mem[sa[f]] >> sh[f]) & 8'h07, s);
			check(dev.mem[cr[f]][1:0], 2'b11);
			check(dev.mem[kb[f]], 16 * s);
			check(dev.mem[kb[f] + 10'hf], 16 * s + 15);
			if (f != 3) begin
				check(res.fail, o_fail);
				check(res.retry, o_retry);
				check(res.chan_busy, o_busy);
				check(res.no_time, f != 0 && o_notime);
			end
		end
		// six non-beacon sends, the suite 000 one included
		check(dev.sends, 6);
		// receive decrypt failing, then passing, with discard on error
		lat = 4'h1;
		o_decerr = 1'b1;
		run(hsec_pkg::OP_RX_DECRYPT, 2'h0, hsec_pkg::SUITE_CBC_128, 1'b1, 8'h80);
		check(res.decrypt_err, 1);
		check(dev.mem[10'h02c][5:3], 5);
		check(dev.rx_starts, 1);
		check(dev.discards, 1);
		check(dev.mem[10'h2bf], 8'h8f);
		o_decerr = 1'b0;
		run(hsec_pkg::OP_RX_DECRYPT, 2'h0, hsec_pkg::SUITE_CTR, 1'b1, 8'h90);
		check(res.decrypt_err, 0);
		check(dev.discards, 1);
		run(hsec_pkg::OP_RX_DISCARD, 2'h0, 3'h0, 1'b0, 8'h00);
		check(dev.discards, 2);
		run(hsec_pkg::OP_RX_SKIP, 2'h0, 3'h0, 1'b0, 8'h00);
		check(dev.mem[10'h02c][7], 1);
		// done may only follow the secured-frame flag
		fork
			begin
				run(hsec_pkg::OP_WAIT_SECURED, 2'h0, 3'h0, 1'b0, 8'h00);
				t_done = $time;
			end
			begin
				repeat (40) @(negedge clk);
				sec_rx = 1'b1;
				t_sec = $time;
				@(negedge clk);
				sec_rx = 1'b0;
			end
		join
		check(32'(t_done > t_sec), 1);
		// upper encrypt stays in place, nothing is sent
		sends0 = dev.sends;
		run(hsec_pkg::OP_UP_ENC, 2'h0, hsec_pkg::SUITE_CCM_64, 1'b0, 8'ha0);
		for (s = 0; s < 13; s++)
			check(dev.mem[10'h240 + 10'(s)], 8'ha0 + 8'(s));
		check(res.fail, 0);
		check(dev.sends, sends0);
		check(dev.mem[10'h037][7:6], 0);
		check(dev.mem[10'h02c][2:0], 3);
		check(dev.mem[10'h01b][1:0], 3);
		// upper decrypt with integrity failure, flag then cleared
		o_integ = 1'b1;
		run(hsec_pkg::OP_UP_DEC, 2'h0, hsec_pkg::SUITE_CCM_32, 1'b0, 8'hb0);
		check(res.integrity_err, 1);
		check(dev.mem[10'h030][6], 0);
		check(dev.mem[10'h01b][1:0], 1);
		check(res.fail, 0);
		check(dev.sends, sends0);
		check(dev.mem[10'h280], 8'hb0);
		test_done();
	end
endmodule
